/* File: common/synchronous_rate_converter_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the rate converter.
// Assumes: APB with 32-bit data; pclk at 40 MHz.
// Notes: Register byte address is four times the register index.
// Function
// - Two independent audio serial ports are provided.
// - Auto detection converts only supported rate ratios.
// - Differing standard rates in a supported ratio auto enable conversion.
// - Clearing conversion enable leaves conversion to auto detection.
// - Auto mode takes higher rate as main.
// - Control bit six disables automatic main port choice.
// - Custom mode lets software pick main port.
// - Capture samples at main, converts to auxiliary.
// - Capture may mix in DAC loopback data.
// - ADC coefficients are weight times two-to-31.
// - Capture coefficients reset to 32'h7ffffff.
// - ADC coefficients live page 0x0A, 0x08-0x47.
// - Loopback coefficients page 0x0A, 0x48-0x67.
// - Auxiliary ADC coefficients weight times two-to-30.
// - Playback converts to main, then mixes.
// - DAC coefficients are 16-bit, two-to-14 scale.
// - DAC main and auxiliary coefficient address ranges.
// - Side chain coefficients page 0x11, 0x58-0x77.
`ifndef SYNCHRONOUS_RATE_CONVERTER_DEFS_SVH
`define SYNCHRONOUS_RATE_CONVERTER_DEFS_SVH
// Register indexes; byte address is index times four.
`define SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL 8'h17
`define SYNCHRONOUS_RATE_CONVERTER_IDX_RATIO 8'h18
`define SYNCHRONOUS_RATE_CONVERTER_IDX_STATUS 8'h19
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC 8'h20
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_LOOP 8'h21
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_AUX 8'h22
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_DMAIN 8'h23
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_DAUX 8'h24
`define SYNCHRONOUS_RATE_CONVERTER_IDX_C_SIDE 8'h25
// Control fields.
`define SYNCHRONOUS_RATE_CONVERTER_BIT_ENABLE 7
`define SYNCHRONOUS_RATE_CONVERTER_BIT_NOAUTO 6
`define SYNCHRONOUS_RATE_CONVERTER_BIT_MAINSEC 0
`define SYNCHRONOUS_RATE_CONVERTER_RATIO_W 6
// Reset values.
`define SYNCHRONOUS_RATE_CONVERTER_RST_CONTROL 8'h00
`define SYNCHRONOUS_RATE_CONVERTER_RST_RATIO 8'h00
`define SYNCHRONOUS_RATE_CONVERTER_RST_C32 32'h7ffffff
`define SYNCHRONOUS_RATE_CONVERTER_RST_C16 16'h4000
// Coefficient shifts.
`define SYNCHRONOUS_RATE_CONVERTER_SH_ADC 31
`define SYNCHRONOUS_RATE_CONVERTER_SH_AUX 30
`define SYNCHRONOUS_RATE_CONVERTER_SH_DAC 14
// Coefficient windows in the device's paged space.
`define SYNCHRONOUS_RATE_CONVERTER_PG_ADC 8'h0a
`define SYNCHRONOUS_RATE_CONVERTER_PG_AUX 8'h0b
`define SYNCHRONOUS_RATE_CONVERTER_PG_DAC 8'h11
// Clock rate in Hz; period tolerance and counter limit in pclk cycles.
`define SYNCHRONOUS_RATE_CONVERTER_CLK_HZ 40000000
`define SYNCHRONOUS_RATE_CONVERTER_TOL 13'h008
`define SYNCHRONOUS_RATE_CONVERTER_CNT_MAX 13'h1fff
`endif

/* File: common/synchronous_rate_converter_pkg.sv */
// Purpose: Types shared by the rate converter.
// Assumes: 24-bit signed audio samples.
// Notes: Rate code 7 means no standard rate found.
package synchronous_rate_converter_pkg;
    // One audio sample with its strobe.
    typedef struct packed {
        logic valid;
        logic signed [23:0] data;
    } synchronous_rate_converter_sample_t;
    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } synchronous_rate_converter_apb_req_t;
    // APB answer to the master.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } synchronous_rate_converter_apb_rsp_t;
    // Standard rate codes.
    typedef enum logic [2:0] {
        SYNCHRONOUS_RATE_CONVERTER_R8K = 3'h0, SYNCHRONOUS_RATE_CONVERTER_R12K = 3'h1, SYNCHRONOUS_RATE_CONVERTER_R16K = 3'h2, SYNCHRONOUS_RATE_CONVERTER_R24K = 3'h3,
        SYNCHRONOUS_RATE_CONVERTER_R32K = 3'h4, SYNCHRONOUS_RATE_CONVERTER_R48K = 3'h5, SYNCHRONOUS_RATE_CONVERTER_R96K = 3'h6, SYNCHRONOUS_RATE_CONVERTER_RNONE = 3'h7
    } synchronous_rate_converter_rate_t;
endpackage

/* File: hdl/synchronous_rate_converter_core.sv */
// Purpose: Synchronous sample rate converter between two audio serial ports.
// Assumes: Port samples arrive on pclk with a strobe; frame clocks are raw pins.
// Notes: Conversion is a sample-and-hold between the two frame rates.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "synchronous_rate_converter_defs.svh"
module synchronous_rate_converter_core (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB register bus.
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_apb_req_t apb_req,
    output synchronous_rate_converter_pkg::synchronous_rate_converter_apb_rsp_t apb_rsp,
    // Frame clock pins of the primary and secondary ports.
    input wire logic primary_serial_port_fsync,
    input wire logic secondary_serial_port_fsync,
    // Received samples and ADC capture samples.
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t primary_rx,
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t secondary_rx,
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t adc_in,
    // Transmit samples and DAC output.
    output synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t primary_tx,
    output synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t secondary_tx,
    output synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t dac_out,
    // Converter running.
    output logic conv_active
);
    import synchronous_rate_converter_pkg::*;

    // Whole state of the block in one record.
    typedef struct packed {
        logic [1:0][1:0] sync;
        logic [1:0] fs_d;
        logic [1:0][12:0] cnt;
        logic [1:0][12:0] per;
        logic [7:0] control;
        logic [7:0] ratio;
        logic signed [31:0] c_adc;
        logic signed [31:0] c_loop;
        logic signed [31:0] c_aux;
        logic signed [15:0] c_dmain;
        logic signed [15:0] c_daux;
        logic signed [15:0] c_side;
        logic signed [23:0] cap;
        logic signed [23:0] adc_h;
        logic signed [23:0] prx_h;
        logic signed [23:0] srx_h;
        synchronous_rate_converter_apb_rsp_t rsp;
        synchronous_rate_converter_sample_t ptx;
        synchronous_rate_converter_sample_t stx;
        synchronous_rate_converter_sample_t dac;
        logic active;
    } synchronous_rate_converter_state_t;

    synchronous_rate_converter_state_t st;
    synchronous_rate_converter_state_t next_st;

    // Nominal frame periods for 8, 12, 16, 24, 32, 48 and 96 kHz.
    localparam int unsigned PER_NOM [7] = '{
        `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 8000, `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 12000, `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 16000,
        `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 24000, `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 32000, `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 48000,
        `SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 96000
    };

    // Classifies a measured frame period into a standard rate.
    function automatic synchronous_rate_converter_rate_t rate_code(input logic [12:0] per);
        rate_code = SYNCHRONOUS_RATE_CONVERTER_RNONE;
        for (int i = 0; i < 7; i++) begin
            if ((per + `SYNCHRONOUS_RATE_CONVERTER_TOL >= 13'(PER_NOM[i])) && (per <= 13'(PER_NOM[i]) + `SYNCHRONOUS_RATE_CONVERTER_TOL)) begin
                rate_code = synchronous_rate_converter_rate_t'(3'(i));
            end
        end
    endfunction

    // Tells whether a pair of rates forms a supported ratio.
    function automatic logic ratio_ok(input synchronous_rate_converter_rate_t a, input synchronous_rate_converter_rate_t b);
        logic hi_a;
        logic hi_b;
        hi_a = (a == SYNCHRONOUS_RATE_CONVERTER_R32K) || (a == SYNCHRONOUS_RATE_CONVERTER_R96K);
        hi_b = (b == SYNCHRONOUS_RATE_CONVERTER_R32K) || (b == SYNCHRONOUS_RATE_CONVERTER_R96K);
        ratio_ok = !((hi_a && (b <= SYNCHRONOUS_RATE_CONVERTER_R12K)) || (hi_b && (a <= SYNCHRONOUS_RATE_CONVERTER_R12K)));
    endfunction

    // Scales a sample by a coefficient; the shift drops the fraction bits.
    function automatic logic signed [63:0] scale(input logic signed [23:0] a,
                                                 input logic signed [31:0] c,
                                                 input int sh);
        scale = (64'(a) * 64'(c)) >>> sh;
    endfunction

    // Clamps a wide sum to the sample range.
    function automatic logic signed [23:0] sat(input logic signed [63:0] v);
        if (v > 64'sh7fffff) begin
            sat = 24'sh7fffff;
        end else if (v < -64'sh800000) begin
            sat = -24'sh800000;
        end else begin
            sat = v[23:0];
        end
    endfunction

    // Decodes an APB byte address into a register index, 8'hff if unmapped.
    function automatic logic [7:0] reg_index(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        reg_index = 8'hff;
        if ((addr[1:0] == 2'h0) && (addr[11:10] == 2'h0)) begin
            if ((idx >= `SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL && idx <= `SYNCHRONOUS_RATE_CONVERTER_IDX_STATUS) ||
                (idx >= `SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC && idx <= `SYNCHRONOUS_RATE_CONVERTER_IDX_C_SIDE)) begin
                reg_index = idx;
            end
        end
    endfunction

    // Next-state logic for frame detection, registers and sample paths.
    always_comb begin
        logic [1:0] rise;
        synchronous_rate_converter_rate_t rc0;
        synchronous_rate_converter_rate_t rc1;
        logic auto_on;
        logic main_sec;
        logic main_rise;
        logic aux_rise;
        logic [7:0] idx;
        logic signed [23:0] main_rx;
        logic signed [23:0] aux_rx;
        logic signed [23:0] aux_out;
        logic [31:0] rdata;
        main_sec = 1'b0;
        rdata = 32'h0;
        next_st = st;
        rise = 2'h0;
        next_st.ptx.valid = 1'b0;
        next_st.stx.valid = 1'b0;
        next_st.dac.valid = 1'b0;

        // Frame clock pins: two-stage synchronisers, then edge timing per port.
        for (int p = 0; p < 2; p++) begin
            next_st.sync[p][0] = (p == 0) ? primary_serial_port_fsync
                                          : secondary_serial_port_fsync;
            next_st.sync[p][1] = st.sync[p][0];
            next_st.fs_d[p] = st.sync[p][1];
            rise[p] = st.sync[p][1] && !st.fs_d[p];
            if (rise[p]) begin
                next_st.per[p] = st.cnt[p] + 13'h001;
                next_st.cnt[p] = 13'h000;
            end else if (st.cnt[p] != `SYNCHRONOUS_RATE_CONVERTER_CNT_MAX) begin
                next_st.cnt[p] = st.cnt[p] + 13'h001;
            end
        end

        // Rate detection and conversion enable.
        rc0 = rate_code(st.per[0]);
        rc1 = rate_code(st.per[1]);
        auto_on = (rc0 != SYNCHRONOUS_RATE_CONVERTER_RNONE) && (rc1 != SYNCHRONOUS_RATE_CONVERTER_RNONE) && (rc0 != rc1) &&
                  ratio_ok(rc0, rc1);
        // Enable bit forces conversion; with it clear only auto detection runs.
        next_st.active = st.control[`SYNCHRONOUS_RATE_CONVERTER_BIT_ENABLE] || auto_on;

        // Main port choice: shorter period wins unless control bit six is set.
        if (st.control[`SYNCHRONOUS_RATE_CONVERTER_BIT_NOAUTO]) begin
            main_sec = st.control[`SYNCHRONOUS_RATE_CONVERTER_BIT_MAINSEC];
        end else begin
            main_sec = st.per[1] < st.per[0];
        end
        main_rise = main_sec ? rise[1] : rise[0];
        aux_rise = main_sec ? rise[0] : rise[1];

        // Hold the newest received sample of each port.
        if (primary_rx.valid) begin
            next_st.prx_h = primary_rx.data;
        end
        if (secondary_rx.valid) begin
            next_st.srx_h = secondary_rx.data;
        end
        main_rx = main_sec ? st.srx_h : st.prx_h;
        aux_rx = main_sec ? st.prx_h : st.srx_h;

        // Capture mix on each ADC strobe with DAC loopback folded in.
        if (adc_in.valid) begin
            next_st.adc_h = adc_in.data;
            next_st.cap = sat(scale(adc_in.data, st.c_adc, `SYNCHRONOUS_RATE_CONVERTER_SH_ADC) +
                              scale(st.dac.data, st.c_loop, `SYNCHRONOUS_RATE_CONVERTER_SH_ADC));
        end

        // Main frame: main port gets the capture, DAC gets the playback mix.
        if (main_rise) begin
            if (main_sec) begin
                next_st.stx = '{valid: 1'b1, data: st.cap};
            end else begin
                next_st.ptx = '{valid: 1'b1, data: st.cap};
            end
            // Auxiliary data enters only when converted to the main rate.
            next_st.dac.valid = 1'b1;
            next_st.dac.data = sat(scale(main_rx, 32'(st.c_dmain), `SYNCHRONOUS_RATE_CONVERTER_SH_DAC) +
                                   (st.active ? scale(aux_rx, 32'(st.c_daux), `SYNCHRONOUS_RATE_CONVERTER_SH_DAC)
                                              : 64'sh0) +
                                   scale(st.adc_h, 32'(st.c_side), `SYNCHRONOUS_RATE_CONVERTER_SH_DAC));
        end

        // Auxiliary frame: held capture leaves at the other rate, if converting.
        aux_out = sat(scale(st.cap, st.c_aux, `SYNCHRONOUS_RATE_CONVERTER_SH_AUX));
        if (aux_rise && st.active) begin
            if (main_sec) begin
                next_st.ptx = '{valid: 1'b1, data: aux_out};
            end else begin
                next_st.stx = '{valid: 1'b1, data: aux_out};
            end
        end

        // APB slave: answer in the access cycle after every setup cycle.
        idx = reg_index(apb_req.paddr);
        next_st.rsp.pready = apb_req.psel && !apb_req.penable;
        next_st.rsp.pslverr = 1'b0;
        next_st.rsp.prdata = 32'h0;
        case (idx)
            `SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL: rdata = {24'h0, st.control};
            `SYNCHRONOUS_RATE_CONVERTER_IDX_RATIO: rdata = {24'h0, st.ratio};
            `SYNCHRONOUS_RATE_CONVERTER_IDX_STATUS: rdata = {24'h0, rc1, rc0, st.active, main_sec};
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC: rdata = st.c_adc;
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_LOOP: rdata = st.c_loop;
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_AUX: rdata = st.c_aux;
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_DMAIN: rdata = {16'h0, st.c_dmain};
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_DAUX: rdata = {16'h0, st.c_daux};
            `SYNCHRONOUS_RATE_CONVERTER_IDX_C_SIDE: rdata = {16'h0, st.c_side};
            default: rdata = 32'h0;
        endcase
        if (apb_req.psel && !apb_req.penable) begin
            // Unmapped addresses, and writes to status, end in an error.
            next_st.rsp.pslverr = (idx == 8'hff) ||
                                  (apb_req.pwrite && idx == `SYNCHRONOUS_RATE_CONVERTER_IDX_STATUS);
            next_st.rsp.prdata = apb_req.pwrite ? 32'h0 : rdata;
        end
        // Writes land at the edge that completes the access phase.
        if (apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite) begin
            case (idx)
                `SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL: next_st.control = apb_req.pwdata[7:0];
                `SYNCHRONOUS_RATE_CONVERTER_IDX_RATIO: next_st.ratio = {2'h0, apb_req.pwdata[`SYNCHRONOUS_RATE_CONVERTER_RATIO_W-1:0]};
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC: next_st.c_adc = apb_req.pwdata;
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_LOOP: next_st.c_loop = apb_req.pwdata;
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_AUX: next_st.c_aux = apb_req.pwdata;
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_DMAIN: next_st.c_dmain = apb_req.pwdata[15:0];
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_DAUX: next_st.c_daux = apb_req.pwdata[15:0];
                `SYNCHRONOUS_RATE_CONVERTER_IDX_C_SIDE: next_st.c_side = apb_req.pwdata[15:0];
                default: next_st.control = st.control;
            endcase
        end
    end

    // State register; DAC coefficients wake at unity, capture ones at 32'h7ffffff.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.control <= `SYNCHRONOUS_RATE_CONVERTER_RST_CONTROL;
            st.ratio <= `SYNCHRONOUS_RATE_CONVERTER_RST_RATIO;
            st.c_adc <= `SYNCHRONOUS_RATE_CONVERTER_RST_C32;
            st.c_loop <= `SYNCHRONOUS_RATE_CONVERTER_RST_C32;
            st.c_aux <= `SYNCHRONOUS_RATE_CONVERTER_RST_C32;
            st.c_dmain <= `SYNCHRONOUS_RATE_CONVERTER_RST_C16;
            st.c_daux <= `SYNCHRONOUS_RATE_CONVERTER_RST_C16;
            st.c_side <= `SYNCHRONOUS_RATE_CONVERTER_RST_C16;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state record.
    assign apb_rsp = st.rsp;
    assign primary_tx = st.ptx;
    assign secondary_tx = st.stx;
    assign dac_out = st.dac;
    assign conv_active = st.active;
endmodule

/* File: sim/synchronous_rate_converter_core_sva.sv */
// Purpose: Port checker for the rate converter.
// Assumes: Zero wait APB; byte address is index times four.
// Notes: Bound to the core; sees its ports only.
`timescale 1ns/100ps
module synchronous_rate_converter_core_sva (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Register bus.
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_apb_req_t apb_req,
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_apb_rsp_t apb_rsp,
    // Streams and state.
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t primary_tx,
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t secondary_tx,
    input wire synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t dac_out,
    input wire logic conv_active
);
    import synchronous_rate_converter_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc; // Access phase of a transfer.
    assign acc = apb_req.psel && apb_req.penable;
    chk_zero_wait: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held too long");
    chk_err_empty: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 0)
        else $error("bad error response");
    chk_status_ro: assert property (acc && apb_req.pwrite && apb_req.paddr == 12'h064
        |-> apb_rsp.pslverr)
        else $error("status write accepted");
    chk_bad_align: assert property (acc && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr)
        else $error("misaligned access accepted");
    chk_dac_main: assert property (dac_out.valid |-> primary_tx.valid || secondary_tx.valid)
        else $error("dac sample without main frame");
    chk_dac_pulse: assert property (dac_out.valid |=> !dac_out.valid)
        else $error("dac valid too long");
    chk_tx_hold: assert property (!primary_tx.valid |-> $stable(primary_tx.data))
        else $error("tx data moved between frames");
    chk_aux_off: assert property (secondary_tx.valid && !dac_out.valid
        |-> conv_active || $past(conv_active))
        else $error("aux sample while idle");
endmodule
bind synchronous_rate_converter_core synchronous_rate_converter_core_sva chk (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .primary_tx(primary_tx),
    .secondary_tx(secondary_tx),
    .dac_out(dac_out),
    .conv_active(conv_active)
);

/* File: sim/synchronous_rate_converter_host_model.sv */
// Purpose: Host on one audio port making frames and samples.
// Assumes: Period in pclk cycles; zero keeps the port silent.
// Notes: Data between strobes toggles so stale reuse shows.
`timescale 1ns/100ps
module synchronous_rate_converter_host_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Frame setup from the bench.
    input wire logic [12:0] period,
    input wire logic signed [23:0] sample,
    // Port pins.
    output logic fsync,
    output synchronous_rate_converter_pkg::synchronous_rate_converter_sample_t rx
);
    import synchronous_rate_converter_pkg::*;
    logic [12:0] cnt; // Position within the frame.
    // The host owns the frame rate; the bench picks rate pairs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 13'h0;
            fsync <= 1'b0;
            rx <= '0;
        end else if (period == 13'h0) begin
            cnt <= 13'h0;
            fsync <= 1'b0;
            rx.valid <= 1'b0;
        end else begin
            cnt <= (cnt + 13'h1 >= period) ? 13'h0 : cnt + 13'h1;
            fsync <= (cnt < (period >> 1));
            rx.valid <= (cnt == 13'h0);
            rx.data <= (cnt == 13'h0) ? sample : ~rx.data;
        end
    end
endmodule

/* File: sim/test_synchronous_rate_converter_core.sv */
// Purpose: Self-checking bench of the rate converter.
// Assumes: Zero wait APB; 40 MHz pclk; half gain main capture and playback mixers.
// Notes: Expectations come from rates, codes and coefficients.
`timescale 1ns/100ps
`include "synchronous_rate_converter_defs.svh"
`define CHK(nm, e, g) \
    begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_synchronous_rate_converter_core;
    import synchronous_rate_converter_pkg::*;
    typedef struct packed {
        synchronous_rate_converter_rate_t pr;
        synchronous_rate_converter_rate_t sr;
        logic [7:0] ctl;
        logic act;
        logic ms;
    } synchronous_rate_converter_case_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    synchronous_rate_converter_apb_req_t req = '0;
    synchronous_rate_converter_apb_rsp_t rsp;
    logic p_fs, s_fs, act;
    synchronous_rate_converter_sample_t p_rx, s_rx, p_tx, s_tx, dac;
    synchronous_rate_converter_sample_t adc = '0;
    logic [12:0] p_per = 13'h0, s_per = 13'h0;
    logic signed [23:0] p_smp = 24'sh0, s_smp = 24'sh0, a_val;
    logic [31:0] rd, v;
    logic err;
    int n_mismatch = 0, checks = 0;
    int khz[7] = '{8, 12, 16, 24, 32, 48, 96};
    logic [11:0] bad[3] = '{12'h000, 12'h05d, 12'h064};
    // Auto with the higher port main, then custom, then an unsupported pair.
    synchronous_rate_converter_case_t cases[4] = '{'{SYNCHRONOUS_RATE_CONVERTER_R48K, SYNCHRONOUS_RATE_CONVERTER_R16K, 8'h00, 1'b1, 1'b0},
        '{SYNCHRONOUS_RATE_CONVERTER_R16K, SYNCHRONOUS_RATE_CONVERTER_R48K, 8'h00, 1'b1, 1'b1},
        '{SYNCHRONOUS_RATE_CONVERTER_R16K, SYNCHRONOUS_RATE_CONVERTER_R48K, 8'h40, 1'b1, 1'b0},
        '{SYNCHRONOUS_RATE_CONVERTER_R96K, SYNCHRONOUS_RATE_CONVERTER_R8K, 8'h00, 1'b0, 1'b0}};
    always #12.5 pclk = ~pclk;
    synchronous_rate_converter_core u_synchronous_rate_converter_core (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .primary_serial_port_fsync(p_fs), .secondary_serial_port_fsync(s_fs),
        .primary_rx(p_rx), .secondary_rx(s_rx), .adc_in(adc), .primary_tx(p_tx),
        .secondary_tx(s_tx), .dac_out(dac), .conv_active(act));
    synchronous_rate_converter_host_model u_host_p (.pclk(pclk), .presetn(presetn), .period(p_per),
        .sample(p_smp), .fsync(p_fs), .rx(p_rx));
    synchronous_rate_converter_host_model u_host_s (.pclk(pclk), .presetn(presetn), .period(s_per),
        .sample(s_smp), .fsync(s_fs), .rx(s_rx));
    // Byte address of a register index.
    function automatic logic [11:0] ad(input logic [7:0] i);
        ad = {2'b00, i, 2'b00};
    endfunction
    // Frame period of a rate code in pclk cycles.
    function automatic logic [12:0] per(input synchronous_rate_converter_rate_t r);
        per = 13'(`SYNCHRONOUS_RATE_CONVERTER_CLK_HZ / 1000 / khz[r]);
    endfunction
    // Positive even sample, so a half gain is exact.
    function automatic logic signed [23:0] rnd();
        rnd = {1'b0, 22'($urandom), 1'b0};
    endfunction
    // One APB transfer; the request holds until ready is sampled.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for ready; an unknown ready keeps waiting.
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short; the whole run needs about 75000 cycles.
    initial begin
        repeat (95000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hacdaef67));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC + 8'(i)), 32'h0);
            `CHK("coef reset", (i < 3) ? `SYNCHRONOUS_RATE_CONVERTER_RST_C32 : {16'h0, `SYNCHRONOUS_RATE_CONVERTER_RST_C16}, rd)
        end
        apb(1'b0, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL), 32'h0);
        `CHK("control reset", {24'h0, `SYNCHRONOUS_RATE_CONVERTER_RST_CONTROL}, rd)
        v = {26'h0, 6'($urandom)};
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_RATIO), v);
        apb(1'b0, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_RATIO), 32'h0);
        `CHK("ratio", v, rd)
        v = {24'h0, 8'($urandom) & 8'hc1};
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL), v);
        apb(1'b0, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL), 32'h0);
        `CHK("control", v, rd)
        // Unmapped, misaligned and read-only places refuse with no data.
        for (int i = 0; i < 3; i++) begin
            apb(i == 2, bad[i], 32'hff);
            `CHK("slverr", 33'h100000000, {err, rd})
        end
        // Half gain on capture and main playback, unity on auxiliary capture, other paths silent.
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_ADC), 32'h40000000);
        // Unity weight on the auxiliary capture mixer, so the other port sees the capture.
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_AUX), 32'h40000000);
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_LOOP), 32'h0);
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_DMAIN), 32'h2000);
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_DAUX), 32'h0);
        apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_C_SIDE), 32'h0);
        a_val = rnd();
        adc <= '{1'b1, a_val};
        @(posedge pclk);
        adc.valid <= 1'b0;
        foreach (cases[k]) begin
            int n;
            apb(1'b1, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_CONTROL), {24'h0, cases[k].ctl});
            p_per <= per(cases[k].pr);
            s_per <= per(cases[k].sr);
            p_smp <= rnd();
            s_smp <= rnd();
            repeat (16000) @(posedge pclk);
            `CHK("active", cases[k].act, act)
            apb(1'b0, ad(`SYNCHRONOUS_RATE_CONVERTER_IDX_STATUS), 32'h0);
            v = {24'h0, cases[k].sr, cases[k].pr, cases[k].act, cases[k].ms};
            `CHK("status", v, rd)
            if (cases[k].act) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (!(cases[k].ms ? s_tx.valid : p_tx.valid) && n < 6000);
                `CHK("main tx valid", 1'b1, cases[k].ms ? s_tx.valid : p_tx.valid)
                `CHK("main tx", a_val >>> 1, cases[k].ms ? s_tx.data : p_tx.data)
                `CHK("dac", (cases[k].ms ? s_smp : p_smp) >>> 1, dac.data)
                // The other port carries the same capture at its own frame rate.
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (!(cases[k].ms ? p_tx.valid : s_tx.valid) && n < 6000);
                `CHK("aux tx valid", 1'b1, cases[k].ms ? p_tx.valid : s_tx.valid)
                `CHK("aux tx", a_val >>> 1, cases[k].ms ? p_tx.data : s_tx.data)
            end
        end
        finish_test();
    end
endmodule
